/* File: include/ilsel_pkg.sv */
// constants for the interrupt level select registers
package ilsel_pkg;

	// special-function register addresses
	localparam logic [7:0] ILSEL_ADDR_MAIN = 8'hb8;
	localparam logic [7:0] ILSEL_ADDR_EXT  = 8'hf7;

	// reset values
	localparam logic [7:0] ILSEL_RESET_MAIN = 8'h00;
	localparam logic [7:0] ILSEL_RESET_EXT  = 8'h00;

	// writable bit masks and fixed read values of unused bits
	localparam logic [7:0] ILSEL_WMASK_MAIN = 8'h3f;
	localparam logic [7:0] ILSEL_WMASK_EXT  = 8'hbf;
	localparam logic [7:0] ILSEL_RFIX_MAIN  = 8'hc0;
	localparam logic [7:0] ILSEL_RFIX_EXT   = 8'h00;

	// read data returned for an address that maps to neither register
	localparam logic [7:0] ILSEL_RDATA_NONE = 8'h00;

	// main register field positions
	localparam int ILSEL_TIMER2_BIT = 5;
	localparam int ILSEL_UART_BIT   = 4;
	localparam int ILSEL_TIMER1_BIT = 3;
	localparam int ILSEL_EXT1_BIT   = 2;
	localparam int ILSEL_TIMER0_BIT = 1;
	localparam int ILSEL_EXT0_BIT   = 0;

	// extended register field positions
	localparam int ILSEL_CLKVLD_BIT = 7;
	localparam int ILSEL_EXT7_BIT   = 5;
	localparam int ILSEL_EXT6_BIT   = 4;
	localparam int ILSEL_EXT5_BIT   = 3;
	localparam int ILSEL_EXT4_BIT   = 2;
	localparam int ILSEL_CONV_BIT   = 1;
	localparam int ILSEL_TIMER3_BIT = 0;

	// level encoding of one selection bit
	localparam logic ILSEL_LEVEL_LOW  = 1'b0;
	localparam logic ILSEL_LEVEL_HIGH = 1'b1;

endpackage

/* File: core/ilsel_reg8.sv */
// one 8-bit level select register with masked write and fixed unused bits
`timescale 1ns/10ps
module ilsel_reg8 #(
	parameter logic [7:0] RESET_VAL = 8'h00,
	parameter logic [7:0] WMASK     = 8'hff,
	parameter logic [7:0] RFIX      = 8'h00
) (
	input  wire logic       i_clk,
	input  wire logic       i_resetn,
	input  wire logic       i_wr,
	input  wire logic [7:0] i_wdata,
	output logic      [7:0] o_value,
	output logic      [7:0] o_rdata
);
	typedef struct packed {
		logic [7:0] val;
	} ilsel_reg8_st_t;

	ilsel_reg8_st_t st_reg;
	ilsel_reg8_st_t st_next;

	// masked write keeps unused bits at zero inside the flop
	always_comb begin
		st_next = st_reg;
		if (i_wr) begin
			st_next.val = (i_wdata & WMASK) | (st_reg.val & ~WMASK);
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			st_reg.val <= RESET_VAL & WMASK;
		end else begin
			st_reg <= st_next;
		end
	end

	assign o_value = st_reg.val;
	// unused bits read as the fixed pattern, not the flop
	assign o_rdata = (st_reg.val & WMASK) | (RFIX & ~WMASK);
endmodule // ilsel_reg8

/* File: core/ilsel_top.sv */
// interrupt level select registers on the special-function register port
`timescale 1ns/10ps
module ilsel_top
	import ilsel_pkg::*;
(
	input  wire logic       i_clk,
	input  wire logic       i_resetn,
	input  wire logic [7:0] i_sfr_addr,
	input  wire logic       i_sfr_wr,
	input  wire logic       i_sfr_rd,
	input  wire logic [7:0] i_sfr_wdata,
	output logic      [7:0] o_sfr_rdata,
	output logic            o_sfr_hit,
	output logic            o_timer2_level_bit,
	output logic            o_uart_level_bit,
	output logic            o_timer1_level_bit,
	output logic            o_ext_int1_level_bit,
	output logic            o_timer0_level_bit,
	output logic            o_ext_int0_level_bit,
	output logic            o_clock_valid_level_bit,
	output logic            o_ext_int7_level_bit,
	output logic            o_ext_int6_level_bit,
	output logic            o_ext_int5_level_bit,
	output logic            o_ext_int4_level_bit,
	output logic            o_conversion_done_level_bit,
	output logic            o_timer3_level_bit
);
	import ilsel_pkg::*;

	// timing as the core sees it:
	//   a write is taken at the rising edge that samples the write strobe
	//   the level outputs follow straight after that same edge
	//   a read is taken at the rising edge that samples the read strobe
	//   read data stands from the next cycle until the following read
	//   the hit flag pulses for one cycle after a mapped read
	//   a read and a write in one cycle return the value held before it
	//   back to back accesses need no idle cycle between them
	//   unmapped addresses are ignored on write and read as zero
	//   unused and reserved bits never reach the level outputs
	// limitation: the address must stand with the strobe; nothing here
	//   latches it, so a core that moves it early hits the wrong register
	// trade-off: read data is registered to keep the outputs glitch free,
	//   at the cost of one cycle of read latency
	// both registers run on the same clock as the core: no synchronisers

	// read port state: data and hit pulse kept in one flop set
	typedef struct packed {
		logic [7:0] rdata;
		logic       hit;
	} ilsel_st_t;

	// state, register values and decoded strobes
	ilsel_st_t  st_reg;
	ilsel_st_t  st_next;
	logic [7:0] main_val;
	logic [7:0] main_rd;
	logic [7:0] ext_val;
	logic [7:0] ext_rd;
	logic       sel_main;
	logic       sel_ext;
	logic       wr_main;
	logic       wr_ext;
	logic       rd_main;
	logic       rd_ext;

	// address decode shared by write strobes and read mux
	function automatic logic addr_is(input logic [7:0] a,
		input logic [7:0] target);
		addr_is = (a == target);
	endfunction

	// a strobe counts only together with its register select
	function automatic logic strobe_at(input logic strobe,
		input logic sel);
		strobe_at = strobe && sel;
	endfunction

	// one level bit out of a stored register value
	function automatic logic level_of(input logic [7:0] v,
		input int pos);
		level_of = v[pos];
	endfunction

	// register selects; the two addresses never overlap
	assign sel_main = addr_is(i_sfr_addr, ILSEL_ADDR_MAIN);
	assign sel_ext  = addr_is(i_sfr_addr, ILSEL_ADDR_EXT);

	// write strobes; unmapped writes reach neither register
	assign wr_main = strobe_at(i_sfr_wr, sel_main);
	assign wr_ext  = strobe_at(i_sfr_wr, sel_ext);

	// read strobes for the registered read mux
	assign rd_main = strobe_at(i_sfr_rd, sel_main);
	assign rd_ext  = strobe_at(i_sfr_rd, sel_ext);

	// main register: timers 0 to 2, uart, ext ints 0 and 1
	// bits 7:6 are not stored, so a stray write there is harmless
	// and the read side shows them as the fixed pattern
	ilsel_reg8 #(
		.RESET_VAL (ILSEL_RESET_MAIN),
		.WMASK     (ILSEL_WMASK_MAIN),
		.RFIX      (ILSEL_RFIX_MAIN)
	) u_main (
		.i_clk    (i_clk),
		.i_resetn (i_resetn),
		.i_wr     (wr_main),
		.i_wdata  (i_sfr_wdata),
		.o_value  (main_val),
		.o_rdata  (main_rd)
	);

	// extended register: clock valid, ext ints 4 to 7, conversion,
	// timer 3; bit 6 is reserved and never stored
	// software is expected to write it as zero anyway
	ilsel_reg8 #(
		.RESET_VAL (ILSEL_RESET_EXT),
		.WMASK     (ILSEL_WMASK_EXT),
		.RFIX      (ILSEL_RFIX_EXT)
	) u_ext (
		.i_clk    (i_clk),
		.i_resetn (i_resetn),
		.i_wr     (wr_ext),
		.i_wdata  (i_sfr_wdata),
		.o_value  (ext_val),
		.o_rdata  (ext_rd)
	);

	// read mux; a read in the cycle of a write sees the old value
	// because both registers only change at the taking edge
	always_comb begin
		st_next     = st_reg;
		st_next.hit = 1'b0;
		if (rd_main) begin
			st_next.rdata = main_rd;
			st_next.hit   = 1'b1;
		end else if (rd_ext) begin
			st_next.rdata = ext_rd;
			st_next.hit   = 1'b1;
		end else if (i_sfr_rd) begin
			st_next.rdata = ILSEL_RDATA_NONE;
		end
	end

	// read port flops; reset clears data and hit
	// read data holds between reads so a slow core can still take it
	// the hit flag is a pulse and must be watched in its cycle
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	// read port outputs straight from the flops
	assign o_sfr_rdata = st_reg.rdata;
	assign o_sfr_hit   = st_reg.hit;

	// main register levels, straight from the register flops
	// every bit: 0 means the low level, 1 the high level
	// the priority logic reads these directly, no extra delay
	// a write shows here in the cycle after the taking edge

	// timer 2 interrupts
	assign o_timer2_level_bit = level_of(main_val, ILSEL_TIMER2_BIT);

	// uart interrupts
	assign o_uart_level_bit = level_of(main_val, ILSEL_UART_BIT);

	// timer 1 interrupts
	assign o_timer1_level_bit = level_of(main_val, ILSEL_TIMER1_BIT);

	// external interrupt 1
	assign o_ext_int1_level_bit = level_of(main_val, ILSEL_EXT1_BIT);

	// timer 0 interrupts
	assign o_timer0_level_bit = level_of(main_val, ILSEL_TIMER0_BIT);

	// external interrupt 0
	assign o_ext_int0_level_bit = level_of(main_val, ILSEL_EXT0_BIT);

	// extended register levels, same encoding as above
	// bit 6 is reserved and has no output
	// the clock valid level sits at the top bit
	// the rest follow from bit 5 down to bit 0

	// clock source valid event
	assign o_clock_valid_level_bit =
		level_of(ext_val, ILSEL_CLKVLD_BIT);

	// external interrupt 7
	assign o_ext_int7_level_bit = level_of(ext_val, ILSEL_EXT7_BIT);

	// external interrupt 6
	assign o_ext_int6_level_bit = level_of(ext_val, ILSEL_EXT6_BIT);

	// external interrupt 5
	assign o_ext_int5_level_bit = level_of(ext_val, ILSEL_EXT5_BIT);

	// external interrupt 4
	assign o_ext_int4_level_bit = level_of(ext_val, ILSEL_EXT4_BIT);

	// conversion done event
	assign o_conversion_done_level_bit =
		level_of(ext_val, ILSEL_CONV_BIT);

	// timer 3 interrupts
	assign o_timer3_level_bit = level_of(ext_val, ILSEL_TIMER3_BIT);

	// end of the level outputs; only the read data and hit flag leave this block besides
endmodule // ilsel_top

/* File: testbench/ilsel_checker.sv */
// assertions on the level select register ports
`timescale 1ns/10ps
module ilsel_checker import ilsel_pkg::*; (
	input logic       i_clk,
	input logic       i_resetn,
	input logic [7:0] i_sfr_addr,
	input logic       i_sfr_wr,
	input logic       i_sfr_rd,
	input logic [7:0] i_sfr_wdata,
	input logic [7:0] o_sfr_rdata,
	input logic       o_timer2_level_bit,
	input logic       o_ext_int0_level_bit,
	input logic       o_clock_valid_level_bit,
	input logic       o_timer3_level_bit
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_resetn);
	wire wm = i_sfr_wr && i_sfr_addr == ILSEL_ADDR_MAIN;
	wire we = i_sfr_wr && i_sfr_addr == ILSEL_ADDR_EXT;
	wire rm = i_sfr_rd && i_sfr_addr == ILSEL_ADDR_MAIN;
	// a taken write shows on the level bit one cycle later
	a_main_timer2: assert property (wm |=> o_timer2_level_bit ==
		$past(i_sfr_wdata[5])) else $error("timer2 level");
	a_main_ext0: assert property (wm |=> o_ext_int0_level_bit ==
		$past(i_sfr_wdata[0])) else $error("ext0 level");
	a_ext_timer3: assert property (we |=> o_timer3_level_bit ==
		$past(i_sfr_wdata[0])) else $error("timer3 level");
	a_ext_clkvld: assert property (we |=> o_clock_valid_level_bit ==
		$past(i_sfr_wdata[7])) else $error("clock valid level");
	a_read_levels: assert property (rm && !i_sfr_wr |=>
		o_sfr_rdata[5] == o_timer2_level_bit) else $error("readback");
	a_unused_ones: assert property (rm |=> o_sfr_rdata[7:6] == 2'b11)
		else $error("unused bits");
endmodule // ilsel_checker
bind ilsel_top ilsel_checker u_chk (.*);

/* File: testbench/testbench.sv */
// self-checking bench for the level select registers
`timescale 1ns/10ps
module testbench;
	import ilsel_pkg::*;
	logic        i_clk = 1'b0, i_resetn = 1'b0;
	logic        i_sfr_wr = 1'b0, i_sfr_rd = 1'b0, hit;
	logic [7:0]  i_sfr_addr = 8'h00, i_sfr_wdata = 8'h00, o_sfr_rdata;
	logic [12:0] lv;
	int          errors = 0, total_checks = 0;
	ilsel_top dut (.i_clk, .i_resetn, .i_sfr_addr, .i_sfr_wr, .i_sfr_rd,
		.i_sfr_wdata, .o_sfr_rdata, .o_sfr_hit(hit),
		.o_timer2_level_bit(lv[12]), .o_uart_level_bit(lv[11]),
		.o_timer1_level_bit(lv[10]), .o_ext_int1_level_bit(lv[9]),
		.o_timer0_level_bit(lv[8]), .o_ext_int0_level_bit(lv[7]),
		.o_clock_valid_level_bit(lv[6]), .o_ext_int7_level_bit(lv[5]),
		.o_ext_int6_level_bit(lv[4]), .o_ext_int5_level_bit(lv[3]),
		.o_ext_int4_level_bit(lv[2]), .o_timer3_level_bit(lv[0]),
		.o_conversion_done_level_bit(lv[1]));
	always #5 i_clk = ~i_clk; // 100 MHz
	task automatic chk(input string what, input logic [7:0] seen, exp);
		total_checks++;
		errors += int'(seen !== exp);
		if (seen !== exp)
			$display("[FAIL] %s exp %h seen %h", what, exp, seen);
	endtask
	// one strobe; read data judged after the taking edge lands
	task automatic bus(input logic w, input logic [7:0] a, d, exp);
		logic [7:0] exp_hit;
		exp_hit = {7'h00, (a == ILSEL_ADDR_MAIN) || (a == ILSEL_ADDR_EXT)};
		@(posedge i_clk);
		{i_sfr_addr, i_sfr_wdata} <= {a, d};
		{i_sfr_wr, i_sfr_rd} <= {w, !w};
		@(posedge i_clk);
		{i_sfr_wr, i_sfr_rd} <= 2'b00;
		#1 if (!w) chk("rdata", o_sfr_rdata, exp);
		if (!w) chk("hit", {7'h00, hit}, exp_hit);
		@(posedge i_clk);
		#1 chk("hit low", {7'h00, hit}, 8'h00);
	endtask
	task automatic reset_midrun; // levels drop on a reset in mid-run
		bus(1'b1, ILSEL_ADDR_MAIN, 8'hff, 8'h00);
		bus(1'b1, ILSEL_ADDR_EXT, 8'hff, 8'h00);
		chk("main", {2'b00, lv[12:7]}, 8'h3f);
		@(posedge i_clk);
		i_resetn <= 1'b0;
		repeat (2) @(posedge i_clk);
		i_resetn <= 1'b1;
		#1 chk("main", {2'b00, lv[12:7]}, 8'h00);
		chk("ext", {lv[6], 1'b0, lv[5:0]}, 8'h00);
		bus(1'b0, ILSEL_ADDR_EXT, 8'h00, 8'h00);
	endtask
	task automatic reset_values; // all low, unused bits read fixed
		chk("main", {2'b00, lv[12:7]}, 8'h00);
		chk("ext", {lv[6], 1'b0, lv[5:0]}, 8'h00);
		bus(1'b0, ILSEL_ADDR_MAIN, 8'h00, 8'hc0);
	endtask
	task automatic fields_and_unmapped; // walking one, then a stray address
		for (int i = 0; i < 8; i++) begin
			bus(1'b1, ILSEL_ADDR_MAIN, 8'h01 << i, 8'h00);
			chk("main", {2'b00, lv[12:7]}, (8'h01 << i) & 8'h3f);
			bus(1'b0, ILSEL_ADDR_MAIN, 8'h00, (8'h01 << i) | 8'hc0);
			bus(1'b1, ILSEL_ADDR_EXT, 8'h01 << i, 8'h00);
			chk("ext", {lv[6], 1'b0, lv[5:0]}, (8'h01 << i) & 8'hbf);
			bus(1'b0, ILSEL_ADDR_EXT, 8'h00, (8'h01 << i) & 8'hbf);
		end
		bus(1'b1, ILSEL_ADDR_EXT, 8'hff, 8'h00);
		bus(1'b1, 8'hb9, 8'h00, 8'h00);
		chk("ext", {lv[6], 1'b0, lv[5:0]}, 8'hbf);
		bus(1'b0, 8'hb9, 8'h00, 8'h00);
	endtask
	initial begin // reset, then the scenarios in turn
		repeat (20) @(posedge i_clk);
		i_resetn <= 1'b1;
		reset_values();
		fields_and_unmapped();
		reset_midrun();
		tally_and_finish();
	end
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
endmodule // testbench
